// >>> rtl/uls_pkg.sv
// Notes on behaviour
// R1: The USB station number is 0 to 31, is 0 after initialisation, and is the device's own USB address.
// R2: With a check interval of zero, USB keeps working but entering panel operation mode trips the USB link fault and shuts off the output.
// The code does not trip when panel mode is entered by the same control write that gives the drive reset.
// R3: An interval of 0.1 to 999.8 s trips the fault after that long without traffic; 9999, the initial value, disables the check.
// The code trips one 0.1 s tick later than that, and starts timing only at the first transaction after a reset.
// R4: A new station number or check interval takes effect only after power-up or a drive reset; power-up in the code loads the initial values instead.
// R5: The USB link runs full speed at 12 Mbps and the host talks at that rate.
// R6: Command source 9999, the initial value, lets USB work in panel operation mode as soon as a cable is attached.
// R7: Command source 3 takes panel-mode commands only from the USB connector.
// R8: The panel-port station range is 0-31 for protocol 0, 0-247 for protocol 1 and 0-127 for protocol 2.
// R9: A panel-port station number outside the range for the selected protocol is replaced by the initial value.
// R10: Drives sharing one operator terminal must each be given a distinct panel-port station number first.
// R11: With automatic connection the device talks to the terminal using only station number and wiring.
// R12: Every valid USB transaction restarts the no-traffic timer, and the fault holds until a drive reset.
package uls_pkg;
    // Register byte offsets
    localparam logic [7:0] ULS_OFS_USB_STATION = 8'h00;
    localparam logic [7:0] ULS_OFS_USB_CHECK   = 8'h04;
    localparam logic [7:0] ULS_OFS_CMD_SOURCE  = 8'h08;
    localparam logic [7:0] ULS_OFS_PANEL_STN   = 8'h0c;
    localparam logic [7:0] ULS_OFS_PROTOCOL    = 8'h10;
    localparam logic [7:0] ULS_OFS_CONTROL     = 8'h14;
    localparam logic [7:0] ULS_OFS_STATUS      = 8'h18;
    localparam logic [7:0] ULS_OFS_ACTIVE      = 8'h1c;

    // Settings, interval in 0.1 s units
    localparam logic [13:0] ULS_DISABLED      = 14'h270f;
    localparam logic [13:0] ULS_CHECK_MAX     = 14'h270e;
    localparam logic [13:0] ULS_CHECK_ZERO    = 14'h0000;
    localparam logic [4:0]  ULS_USB_STN_INIT  = 5'h00;
    localparam logic [7:0]  ULS_PANEL_STN_INIT = 8'h00;
    localparam logic [7:0]  ULS_STN_MAX_VENDOR = 8'h1f;
    localparam logic [7:0]  ULS_STN_MAX_MODBUS = 8'hf7;
    localparam logic [7:0]  ULS_STN_MAX_BACNET = 8'h7f;
    localparam logic [1:0]  ULS_PROTO_VENDOR  = 2'h0;
    localparam logic [1:0]  ULS_PROTO_MODBUS  = 2'h1;
    localparam logic [1:0]  ULS_PROTO_BACNET  = 2'h2;
    localparam logic [13:0] ULS_SRC_USB_ONLY  = 14'h0003;
    localparam logic [13:0] ULS_SRC_AUTO      = 14'h270f;

    // Control and status bit positions
    localparam int ULS_CTL_RESET_BIT  = 0;
    localparam int ULS_CTL_PANEL_BIT  = 1;
    localparam int ULS_CTL_AUTO_BIT   = 2;
    localparam int ULS_ST_FAULT_BIT   = 0;
    localparam int ULS_ST_SHUT_BIT    = 1;
    localparam int ULS_ST_USBCMD_BIT  = 2;
    localparam int ULS_ST_ATTACH_BIT  = 3;

    // Timing
    localparam int ULS_CLK_HZ        = 250_000_000;
    localparam int ULS_TICK_MS       = 100;
    localparam int ULS_TICK_CYCLES   = ULS_CLK_HZ / 1000 * ULS_TICK_MS;
    localparam int ULS_USB_BPS       = 12_000_000;

    typedef enum logic [2:0]
    {
        ULS_ST_IDLE  = 3'b001,
        ULS_ST_WATCH = 3'b010,
        ULS_ST_FAULT = 3'b100
    } uls_state_e;
endpackage

// >>> rtl/uls_supervisor.sv
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module uls_supervisor #(
    parameter int TICK_CYCLES = uls_pkg::ULS_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // USB core status, from the link's own clock domain
    input  wire logic        usb_txn_toggle,
    input  wire logic        usb_attached,
    // Drive outputs
    output logic [4:0]       usb_address,
    output logic [7:0]       panel_station_active,
    output logic             usb_link_fault,
    output logic             output_shutoff,
    output logic             usb_command_only,
    output logic             usb_panel_enable
);
    import uls_pkg::*;

    // Software-written settings (USB station and check interval pending)
    logic [4:0]  usb_stn_reg,    usb_stn_next;
    logic [13:0] check_reg,      check_next;
    logic [13:0] cmd_src_reg,    cmd_src_next;
    logic [7:0]  panel_stn_reg,  panel_stn_next;
    logic [1:0]  proto_reg,      proto_next;
    logic        panel_mode_reg, panel_mode_next;
    logic        auto_conn_reg,  auto_conn_next;
    // Settings in effect since the last drive reset, then watchdog, sync and bus state
    logic [4:0]  act_stn_reg,    act_stn_next;
    logic [13:0] act_check_reg,  act_check_next;
    logic [13:0] tick_cnt_reg,   tick_cnt_next;
    logic        fault_reg,      fault_next;
    logic        panel_d_reg,    panel_d_next;
    logic        drv_rst_reg,    drv_rst_next;
    uls_state_e  state_reg,      state_next;
    logic [2:0]  txn_sync_reg;
    logic [1:0]  att_sync_reg;
    logic [31:0] rdata_reg,      rdata_next;
    logic        txn_pulse;
    logic        tick;
    logic        wr_en;
    logic        rd_en;
    logic        addr_ok;

    function automatic logic [7:0] stn_limit(input logic [1:0] proto);
        case (proto)
            ULS_PROTO_VENDOR: stn_limit = ULS_STN_MAX_VENDOR;
            ULS_PROTO_MODBUS: stn_limit = ULS_STN_MAX_MODBUS;
            ULS_PROTO_BACNET: stn_limit = ULS_STN_MAX_BACNET;
            default:          stn_limit = ULS_STN_MAX_VENDOR;
        endcase
    endfunction

    function automatic logic known_addr(input logic [7:0] a);
        known_addr = (a == ULS_OFS_USB_STATION) || (a == ULS_OFS_USB_CHECK) ||
                     (a == ULS_OFS_CMD_SOURCE) || (a == ULS_OFS_PANEL_STN) ||
                     (a == ULS_OFS_PROTOCOL) || (a == ULS_OFS_CONTROL) ||
                     (a == ULS_OFS_STATUS) || (a == ULS_OFS_ACTIVE);
    endfunction

    // Zero-wait APB: every access ends in its first access cycle
    assign addr_ok = known_addr(paddr);
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign wr_en   = psel && penable && pwrite && addr_ok;
    assign rd_en   = psel && !penable && !pwrite;
    assign prdata  = rdata_reg;

    // Transaction events arrive as a toggle from the full-speed USB domain [R5]
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            txn_sync_reg <= 3'h0;
            att_sync_reg <= 2'h0;
        end
        else
        begin
            txn_sync_reg <= {txn_sync_reg[1:0], usb_txn_toggle};
            att_sync_reg <= {att_sync_reg[0], usb_attached};
        end
    end
    assign txn_pulse = txn_sync_reg[2] ^ txn_sync_reg[1];

    uls_tick_div #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .restart (txn_pulse || drv_rst_reg),
        .tick    (tick)
    );

    always_comb
    begin
        usb_stn_next    = usb_stn_reg;
        check_next      = check_reg;
        cmd_src_next    = cmd_src_reg;
        panel_stn_next  = panel_stn_reg;
        proto_next      = proto_reg;
        panel_mode_next = panel_mode_reg;
        auto_conn_next  = auto_conn_reg;
        drv_rst_next    = 1'b0;
        rdata_next      = rdata_reg;
        if (wr_en)
        begin
            case (paddr)
                ULS_OFS_USB_STATION:
                begin
                    if (pwdata[7:0] <= 8'(ULS_STN_MAX_VENDOR))
                        usb_stn_next = pwdata[4:0]; // [R1]
                end
                ULS_OFS_USB_CHECK:
                begin
                    if (pwdata[13:0] <= ULS_CHECK_MAX || pwdata[13:0] == ULS_DISABLED)
                        check_next = pwdata[13:0];
                end
                ULS_OFS_CMD_SOURCE: cmd_src_next   = pwdata[13:0];
                ULS_OFS_PANEL_STN:  panel_stn_next = pwdata[7:0];
                ULS_OFS_PROTOCOL:   proto_next     = pwdata[1:0];
                ULS_OFS_CONTROL:
                begin
                    drv_rst_next    = pwdata[ULS_CTL_RESET_BIT];
                    panel_mode_next = pwdata[ULS_CTL_PANEL_BIT];
                    auto_conn_next  = pwdata[ULS_CTL_AUTO_BIT];
                end
                default: ;
            endcase
        end
        if (rd_en)
        begin
            case (paddr)
                ULS_OFS_USB_STATION: rdata_next = {27'h0, usb_stn_reg};
                ULS_OFS_USB_CHECK:   rdata_next = {18'h0, check_reg};
                ULS_OFS_CMD_SOURCE:  rdata_next = {18'h0, cmd_src_reg};
                ULS_OFS_PANEL_STN:   rdata_next = {24'h0, panel_stn_reg};
                ULS_OFS_PROTOCOL:    rdata_next = {30'h0, proto_reg};
                ULS_OFS_CONTROL:     rdata_next = {29'h0, auto_conn_reg, panel_mode_reg, 1'b0};
                ULS_OFS_STATUS:      rdata_next = {28'h0, att_sync_reg[1], usb_command_only,
                                                   fault_reg, fault_reg};
                ULS_OFS_ACTIVE:      rdata_next = {3'h0, act_stn_reg, 10'h0, act_check_reg};
                default:             rdata_next = 32'h0;
            endcase
        end
    end

    // Watchdog on settings latched at drive reset
    always_comb
    begin
        act_stn_next   = act_stn_reg;
        act_check_next = act_check_reg;
        tick_cnt_next  = tick_cnt_reg;
        fault_next     = fault_reg;
        panel_d_next   = panel_mode_reg;
        state_next     = state_reg;
        if (drv_rst_reg)
        begin
            act_stn_next   = usb_stn_reg;   // [R4]
            act_check_next = check_reg;     // [R4]
            tick_cnt_next  = 14'h0;
            fault_next     = 1'b0;          // [R12]
            state_next     = ULS_ST_IDLE;
        end
        else
        begin
            case (state_reg)
                ULS_ST_IDLE:
                begin
                    tick_cnt_next = 14'h0;
                    if (act_check_reg == ULS_CHECK_ZERO)
                    begin
                        if (panel_mode_reg && !panel_d_reg)
                            state_next = ULS_ST_FAULT; // [R2]
                    end
                    else if (act_check_reg != ULS_DISABLED && txn_pulse)
                        state_next = ULS_ST_WATCH; // [R3]
                end
                ULS_ST_WATCH:
                begin
                    if (txn_pulse)
                        tick_cnt_next = 14'h0; // [R12]
                    else if (tick)
                    begin
                        tick_cnt_next = tick_cnt_reg + 14'h1;
                        if (tick_cnt_reg >= act_check_reg)
                            state_next = ULS_ST_FAULT; // [R3]
                    end
                end
                ULS_ST_FAULT: fault_next = 1'b1; // [R12]
                default:      state_next = ULS_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            usb_stn_reg    <= ULS_USB_STN_INIT;
            check_reg      <= ULS_DISABLED;
            cmd_src_reg    <= ULS_SRC_AUTO;
            panel_stn_reg  <= ULS_PANEL_STN_INIT;
            proto_reg      <= ULS_PROTO_VENDOR;
            panel_mode_reg <= 1'b0;
            auto_conn_reg  <= 1'b0;
            drv_rst_reg    <= 1'b0;
            rdata_reg      <= 32'h0;
            act_stn_reg    <= ULS_USB_STN_INIT;
            act_check_reg  <= ULS_DISABLED;
            tick_cnt_reg   <= 14'h0;
            fault_reg      <= 1'b0;
            panel_d_reg    <= 1'b0;
            state_reg      <= ULS_ST_IDLE;
        end
        else
        begin
            usb_stn_reg    <= usb_stn_next;
            check_reg      <= check_next;
            cmd_src_reg    <= cmd_src_next;
            panel_stn_reg  <= panel_stn_next;
            proto_reg      <= proto_next;
            panel_mode_reg <= panel_mode_next;
            auto_conn_reg  <= auto_conn_next;
            drv_rst_reg    <= drv_rst_next;
            rdata_reg      <= rdata_next;
            act_stn_reg    <= act_stn_next;
            act_check_reg  <= act_check_next;
            tick_cnt_reg   <= tick_cnt_next;
            fault_reg      <= fault_next;
            panel_d_reg    <= panel_d_next;
            state_reg      <= state_next;
        end
    end

    assign usb_address    = act_stn_reg; // [R1]
    assign usb_link_fault = fault_reg;
    assign output_shutoff = fault_reg;   // [R2] [R3]
    // Out-of-range panel station falls back to the initial value
    assign panel_station_active = (panel_stn_reg <= stn_limit(proto_reg)) ?
                                  panel_stn_reg : ULS_PANEL_STN_INIT; // [R8] [R9]
    // Auto connection needs nothing beyond the station number
    assign usb_command_only = panel_mode_reg && (cmd_src_reg == ULS_SRC_USB_ONLY); // [R7] [R11]
    assign usb_panel_enable = att_sync_reg[1] &&
                              (cmd_src_reg == ULS_SRC_AUTO || cmd_src_reg == ULS_SRC_USB_ONLY); // [R6]
endmodule
`default_nettype wire

// >>> rtl/uls_tick_div.sv
`timescale 1ns/1ps
`default_nettype none
module uls_tick_div #(
    parameter int TICK_CYCLES = uls_pkg::ULS_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Control
    input  wire logic restart,
    output logic      tick
);
    import uls_pkg::*;

    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic        tick_reg;
    logic        tick_next;

    assign tick = tick_reg;

    always_comb
    begin
        cnt_next  = cnt_reg + 32'h1;
        tick_next = 1'b0;
        if (restart)
        begin
            cnt_next = 32'h0;
        end
        else if (cnt_reg == 32'(TICK_CYCLES - 1))
        begin
            cnt_next  = 32'h0;
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_reg  <= 32'h0;
            tick_reg <= 1'b0;
        end
        else
        begin
            cnt_reg  <= cnt_next;
            tick_reg <= tick_next;
        end
    end
endmodule
`default_nettype wire

// >>> tb/uls_checker.sv
`timescale 1ns/1ps
`default_nettype none
module uls_checker
    import uls_pkg::*;
(
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // Drive outputs
    input wire logic [4:0]  usb_address,
    input wire logic [7:0]  panel_station_active,
    input wire logic        usb_link_fault,
    input wire logic        output_shutoff
);
    default clocking dcb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    wire logic ctl_rst_wr;
    assign ctl_rst_wr = psel && penable && pwrite && (paddr == ULS_OFS_CONTROL)
                        && pwdata[ULS_CTL_RESET_BIT];

    sequence drive_reset_s;
        ctl_rst_wr;
    endsequence
    sequence read_setup_s(a);
        psel && !penable && !pwrite && (paddr == a);
    endsequence

    AST_SHUTOFF_TRACKS: assert property (output_shutoff == usb_link_fault)
        else $error("shutoff differs from link fault");
    AST_FAULT_HOLDS: assert property ($fell(usb_link_fault) |->
        $past(ctl_rst_wr, 1) || $past(ctl_rst_wr, 2))
        else $error("link fault cleared without drive reset");
    AST_ADDR_HOLDS: assert property (!$stable(usb_address) |->
        $past(ctl_rst_wr, 1) || $past(ctl_rst_wr, 2))
        else $error("usb address changed without drive reset");
    AST_RESET_CLEARS: assert property (drive_reset_s |-> ##[1:3] !usb_link_fault)
        else $error("drive reset left link fault set");
    AST_PANEL_RANGE: assert property (panel_station_active <= ULS_STN_MAX_MODBUS)
        else $error("panel station beyond widest range");
    AST_STATUS_FAULT: assert property (read_setup_s(ULS_OFS_STATUS) |=>
        prdata[ULS_ST_FAULT_BIT] == $past(usb_link_fault)
        && prdata[ULS_ST_SHUT_BIT] == $past(output_shutoff))
        else $error("status read disagrees with fault outputs");
    AST_SLVERR_ACCESS: assert property (pslverr |-> psel && penable)
        else $error("slave error outside access phase");
    AST_UNMAPPED_ERR: assert property (psel && penable && paddr >= 8'h20 |-> pslverr)
        else $error("unmapped access not refused");
    AST_UNMAPPED_RD0: assert property (psel && !penable && !pwrite && paddr >= 8'h20
        |=> prdata == 32'h0)
        else $error("unmapped read returned data");
endmodule
`default_nettype wire

// >>> tb/uls_usb_host.sv
`timescale 1ns/1ps
`default_nettype none
module uls_usb_host (
    // Clock
    input wire logic       pclk,
    // Commands from the bench
    input wire logic       attach,
    input wire logic       traffic_on,
    input wire logic [7:0] gap,
    // Link status towards the device
    output var logic       usb_txn_toggle,
    output var logic       usb_attached
);
    logic [7:0] cnt;

    initial
    begin
        usb_txn_toggle = 1'b0;
        usb_attached   = 1'b0;
        cnt            = 8'h00;
    end

    // Host paces whole transactions by gap, one toggle every gap+1 clocks
    always @(posedge pclk)
    begin
        usb_attached <= attach;
        cnt          <= traffic_on ? cnt + 8'h01 : 8'h00;
        if (traffic_on && cnt >= gap)
        begin
            cnt            <= 8'h00;
            usb_txn_toggle <= ~usb_txn_toggle;
        end
    end
endmodule
`default_nettype wire

// >>> tb/usb_link_supervision_tb.sv
`timescale 1ns/1ps
`default_nettype none
module usb_link_supervision_tb;
    import uls_pkg::*;
    localparam int TICK = 10;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr, panel_station_active, gap, stn;
    logic [31:0] pwdata, prdata, rd, seed_ret;
    logic        usb_txn_toggle, usb_attached, attach, traffic_on;
    logic        usb_link_fault, output_shutoff, usb_command_only, usb_panel_enable;
    logic [4:0]  usb_address, ustn;
    int          num_errors, check_count, i;

    uls_supervisor #(.TICK_CYCLES(TICK)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .usb_txn_toggle(usb_txn_toggle),
        .usb_attached(usb_attached), .usb_address(usb_address),
        .panel_station_active(panel_station_active), .usb_link_fault(usb_link_fault),
        .output_shutoff(output_shutoff), .usb_command_only(usb_command_only),
        .usb_panel_enable(usb_panel_enable));
    uls_usb_host u_host (.pclk(pclk), .attach(attach), .traffic_on(traffic_on), .gap(gap),
        .usb_txn_toggle(usb_txn_toggle), .usb_attached(usb_attached));

    always #2 pclk = ~pclk;

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input int wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= 1'(wr);
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 16)
        begin
            num_errors++;
            give_verdict();
        end
    endtask

    task automatic wait_fault(input int lo, input int hi);
        int n;
        // Fault is looked at away from the edge that sets it
        for (n = 0; n < hi; n++)
        begin
            @(negedge pclk);
            if (usb_link_fault === 1'b1)
                break;
        end
        @(posedge pclk);
        chk({31'h0, n >= lo}, 32'h1);
        if (n == hi)
        begin
            num_errors++;
            give_verdict();
        end
    endtask

    function automatic logic [7:0] stn_max(input logic [1:0] p);
        return (p == ULS_PROTO_MODBUS) ? ULS_STN_MAX_MODBUS :
               (p == ULS_PROTO_BACNET) ? ULS_STN_MAX_BACNET : ULS_STN_MAX_VENDOR;
    endfunction

    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        attach = 1'b0;
        traffic_on = 1'b0;
        gap = 8'h14;
        num_errors = 0;
        check_count = 0;
        seed_ret = $urandom(32'h62c8);
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, ULS_OFS_USB_STATION, 0); chk(rd, 32'h0);
        apb(0, ULS_OFS_USB_CHECK, 0); chk(rd, {18'h0, ULS_DISABLED});
        apb(0, ULS_OFS_CMD_SOURCE, 0); chk(rd, {18'h0, ULS_SRC_AUTO});
        apb(0, 8'h20, 0); chk({31'h0, err}, 32'h1);
        apb(1, 8'h24, 32'h5); chk({31'h0, err}, 32'h1);
        // Panel mode with auto connect; cable alone opens USB
        attach <= 1'b1; traffic_on <= 1'b1;
        apb(1, ULS_OFS_CONTROL, 32'h6);
        apb(0, ULS_OFS_CONTROL, 0);
        chk(rd, 32'h6);
        repeat (6) @(posedge pclk);
        chk({31'h0, usb_panel_enable}, 32'h1);
        apb(1, ULS_OFS_CMD_SOURCE, {18'h0, ULS_SRC_USB_ONLY});
        @(posedge pclk);
        chk({31'h0, usb_command_only}, 32'h1);
        apb(1, ULS_OFS_CMD_SOURCE, {18'h0, ULS_SRC_AUTO});
        @(posedge pclk);
        chk({31'h0, usb_command_only}, 32'h0);
        traffic_on <= 1'b0; attach <= 1'b0;
        repeat (100) @(posedge pclk);
        chk({31'h0, usb_link_fault}, 32'h0);
        chk({31'h0, usb_panel_enable}, 32'h0);
        apb(1, ULS_OFS_CONTROL, 32'h0);
        // Boundaries first, then random stations, for each protocol
        for (i = 0; i < 16; i++)
        begin
            stn = (i < 8) ? stn_max(2'(i % 4)) + 8'(i / 4) : 8'($urandom);
            apb(1, ULS_OFS_PROTOCOL, i % 4);
            apb(1, ULS_OFS_PANEL_STN, {24'h0, stn});
            @(posedge pclk);
            chk({24'h0, panel_station_active},
                {24'h0, ((stn <= stn_max(2'(i % 4))) ? stn : ULS_PANEL_STN_INIT)});
        end
        ustn = 5'($urandom_range(31, 1));
        apb(1, ULS_OFS_USB_STATION, {27'h0, ustn});
        apb(1, ULS_OFS_USB_STATION, 32'h20);
        apb(0, ULS_OFS_USB_STATION, 0); chk(rd, {27'h0, ustn});
        apb(1, ULS_OFS_USB_CHECK, 32'h3);
        apb(0, ULS_OFS_ACTIVE, 0); chk({18'h0, rd[13:0]}, {18'h0, ULS_DISABLED});
        chk({27'h0, usb_address}, 32'h0);
        apb(1, ULS_OFS_CONTROL, 32'h1);
        apb(0, ULS_OFS_ACTIVE, 0); chk({18'h0, rd[13:0]}, 32'h3);
        chk({27'h0, usb_address}, {27'h0, ustn});
        // Traffic faster than the interval keeps the watchdog quiet
        traffic_on <= 1'b1;
        repeat (200) @(posedge pclk);
        chk({31'h0, usb_link_fault}, 32'h0);
        traffic_on <= 1'b0;
        wait_fault(20, 70);
        traffic_on <= 1'b1;
        repeat (50) @(posedge pclk);
        apb(0, ULS_OFS_STATUS, 0); chk({30'h0, rd[1:0]}, 32'h3);
        traffic_on <= 1'b0;
        apb(1, ULS_OFS_CONTROL, 32'h1);
        apb(0, ULS_OFS_STATUS, 0); chk({31'h0, rd[0]}, 32'h0);
        // Zero interval trips on entering panel mode
        apb(1, ULS_OFS_USB_CHECK, 32'h0);
        apb(1, ULS_OFS_CONTROL, 32'h1);
        repeat (20) @(posedge pclk);
        chk({31'h0, usb_link_fault}, 32'h0);
        apb(1, ULS_OFS_CONTROL, 32'h2);
        wait_fault(0, 10);
        apb(1, ULS_OFS_CONTROL, 32'h1);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({27'h0, usb_address}, 32'h0);
        apb(0, ULS_OFS_USB_CHECK, 0);
        chk(rd, {18'h0, ULS_DISABLED});
        give_verdict();
    end
endmodule

bind uls_supervisor uls_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pslverr(pslverr), .usb_address(usb_address), .panel_station_active(panel_station_active),
    .usb_link_fault(usb_link_fault), .output_shutoff(output_shutoff));
`default_nettype wire
